// ### logic/ppc_pkg.sv
package ppc_pkg;

    localparam int unsigned PIN_N = 8;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_POL = 10'h2d8;
    localparam logic [9:0] IDX_PULL = 10'h2d9;
    localparam logic [9:0] IDX_IE = 10'h2da;
    localparam logic [9:0] IDX_IF = 10'h2db;
    localparam logic [9:0] IDX_IBE = 10'h2dc;
    localparam logic [9:0] IDX_RDR = 10'h2dd;
    localparam logic [9:0] IDX_OD = 10'h2df;

    localparam logic [7:0] RST_OD = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PIN_N-1:0] pull_en;
        logic [PIN_N-1:0] pull_dn;
        logic [PIN_N-1:0] open_drain;
        logic [PIN_N-1:0] reduced_drv;
        logic [PIN_N-1:0] ibuf_en;
    } ppc_pad_t;

    typedef struct packed {
        logic [9:0] idx;
        logic [7:0] data;
        logic lane0;
    } ppc_wr_t;

endpackage

// ### logic/ppc_port_cfg.sv
// Function
// - Polarity bit 1 pulldown, 0 pullup
// - Polarity bit picks rising or falling edge
// - CAN receive pin: pulldown request disables pull while can_active
// - Unimplemented bits always read zero
// - Config registers readable and writable anytime
// - Enable bit gates flag onto interrupt
// - Edges detected in any pin mode
// - Active edge sets flag; interrupt when enabled
// - Write one clears flag, zero keeps
// - Input buffer enable, forced by peripheral
// - Reduced drive bit selects weak output
// - Open-drain register eight bits, reset zero
// - Open-drain drives low only
// - Pull only on input or open-drain
`timescale 1ns/1ps
module ppc_port_cfg #(
    parameter logic [7:0] IMPL_MASK = 8'hff,
    parameter int unsigned CAN_PIN = 0,
    parameter int unsigned ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] pad_i,
    output logic [7:0] pad_o,
    output logic [7:0] pad_oe_n,
    output ppc_pkg::ppc_pad_t pad_ctrl,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] periph_dig_en,
    input wire logic can_active,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    logic aw_full_r;
    logic w_full_r;
    logic [9:0] aw_idx_r;
    logic [7:0] w_data_r;
    logic w_lane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_do;
    ppc_pkg::ppc_wr_t wr;
    logic wr_hit;
    logic [7:0] rd_val;
    logic rd_hit;

    logic [7:0] pol_r;
    logic [7:0] pull_r;
    logic [7:0] ie_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] ibe_r;
    logic [7:0] rdr_r;
    logic [7:0] od_r;

    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] prev_r;
    logic [7:0] edge_set;
    logic [7:0] flag_clr;
    logic [7:0] can_block;
    logic irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign awready = !aw_full_r && !bvalid_r;
    assign wready = !w_full_r && !bvalid_r;
    assign wr_do = aw_full_r && w_full_r && !bvalid_r;
    assign wr.idx = aw_idx_r;
    assign wr.data = w_data_r & IMPL_MASK;
    assign wr.lane0 = w_lane0_r;

    always_comb
    begin
        case (wr.idx)
            ppc_pkg::IDX_POL, ppc_pkg::IDX_PULL, ppc_pkg::IDX_IE, ppc_pkg::IDX_IF,
            ppc_pkg::IDX_IBE, ppc_pkg::IDX_RDR, ppc_pkg::IDX_OD: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_idx_r <= 10'h000;
            w_data_r <= 8'h00;
            w_lane0_r <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_full_r <= 1'b1;
                aw_idx_r <= awaddr[11:2];
            end
            else if (wr_do)
            begin
                aw_full_r <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_full_r <= 1'b1;
                w_data_r <= wdata[7:0];
                w_lane0_r <= wstrb[0];
            end
            else if (wr_do)
            begin
                w_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= ppc_pkg::RESP_OKAY;
        end
        else if (wr_do)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    ////////////////////////////////////////////////////////////////////////
    // Config registers, writable at any time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pol_r <= ppc_pkg::RST_CFG;
            pull_r <= ppc_pkg::RST_CFG;
            ie_r <= ppc_pkg::RST_CFG;
            ibe_r <= ppc_pkg::RST_CFG;
            rdr_r <= ppc_pkg::RST_CFG;
            od_r <= ppc_pkg::RST_OD;
        end
        else if (wr_do && wr.lane0)
        begin
            case (wr.idx)
                ppc_pkg::IDX_POL: pol_r <= wr.data;
                ppc_pkg::IDX_PULL: pull_r <= wr.data;
                ppc_pkg::IDX_IE: ie_r <= wr.data;
                ppc_pkg::IDX_IBE: ibe_r <= wr.data;
                ppc_pkg::IDX_RDR: rdr_r <= wr.data;
                ppc_pkg::IDX_OD: od_r <= wr.data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detect, independent of direction/function
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            prev_r <= 8'h00;
        end
        else
        begin
            sync1_r <= pad_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Polarity 1 picks rising, 0 falling
    assign edge_set = IMPL_MASK & ((pol_r & sync2_r & ~prev_r) | (~pol_r & ~sync2_r & prev_r));

    assign flag_clr = (wr_do && wr.lane0 && wr.idx == ppc_pkg::IDX_IF) ? wr.data : 8'h00;
    // Set wins over a simultaneous clear
    assign flags_nxt = (flags_r & ~flag_clr) | edge_set;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_r <= ppc_pkg::RST_FLAGS;
            irq_r <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            irq_r <= |(flags_r & ie_r);
        end
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Pad controls
    always_comb
    begin
        can_block = 8'h00;
        can_block[CAN_PIN] = can_active && pol_r[CAN_PIN];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_ctrl <= '0;
            pad_o <= 8'h00;
            pad_oe_n <= 8'hff;
        end
        else
        begin
            // Pull on inputs or open-drain, pullup only on open-drain outputs
            pad_ctrl.pull_en <= pull_r & (~port_dir | od_r) & ~(port_dir & od_r & pol_r)
                & ~can_block;
            pad_ctrl.pull_dn <= pol_r;
            pad_ctrl.open_drain <= od_r;
            pad_ctrl.reduced_drv <= rdr_r;
            // Peripheral digital use forces the buffer on
            pad_ctrl.ibuf_en <= (ibe_r | periph_dig_en) & IMPL_MASK;
            pad_o <= port_out & ~od_r;
            pad_oe_n <= ~(port_dir & ~(od_r & port_out));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    always_comb
    begin
        rd_hit = 1'b1;
        case (araddr[11:2])
            ppc_pkg::IDX_POL: rd_val = pol_r;
            ppc_pkg::IDX_PULL: rd_val = pull_r;
            ppc_pkg::IDX_IE: rd_val = ie_r;
            ppc_pkg::IDX_IF: rd_val = flags_r;
            ppc_pkg::IDX_IBE: rd_val = ibe_r;
            ppc_pkg::IDX_RDR: rd_val = rdr_r;
            ppc_pkg::IDX_OD: rd_val = od_r;
            default:
            begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign arready = !rvalid_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= ppc_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_val & IMPL_MASK};
            rresp_r <= rd_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_pin0_rise;
        $rose(pad_i[0]) && pol_r[0] && IMPL_MASK[0] && !wr_do ##1
            (pad_i[0] && pol_r[0] && !wr_do)[*2];
    endsequence

    property p_rise_flag;
        s_pin0_rise |-> ##[1:2] flags_r[0];
    endproperty
    a_rise_flag: assert property (p_rise_flag)
        else $error("rising edge did not set flag");

    property p_no_spurious;
        ((flags_r & ~$past(flags_r)) & ~$past(edge_set)) == 8'h00;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("flag set without edge");

    property p_w1c;
        (wr_do && wr.lane0 && wr.idx == ppc_pkg::IDX_IF && edge_set == 8'h00) |=>
            flags_r == ($past(flags_r) & ~$past(wr.data));
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("flag clear wrong");

    property p_irq_mask;
        (flags_r & ie_r) == 8'h00 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("masked flag raised irq");

    property p_can_pull;
        (can_active && pol_r[CAN_PIN]) |=> !pad_ctrl.pull_en[CAN_PIN];
    endproperty
    a_can_pull: assert property (p_can_pull)
        else $error("pulldown on can receive pin");

    property p_od_low;
        (pad_ctrl.open_drain & pad_o) == 8'h00;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain pin drove high");

    property p_pp_nopull;
        ($past(port_dir & ~od_r) & pad_ctrl.pull_en) == 8'h00;
    endproperty
    a_pp_nopull: assert property (p_pp_nopull)
        else $error("pull on push-pull output");

    property p_ibe_force;
        $past(periph_dig_en & IMPL_MASK) == ($past(periph_dig_en & IMPL_MASK) & pad_ctrl.ibuf_en);
    endproperty
    a_ibe_force: assert property (p_ibe_force)
        else $error("peripheral did not force buffer");

    property p_unimpl;
        rvalid |-> (rdata & ~{24'h00_0000, IMPL_MASK}) == 32'h0000_0000;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bit read nonzero");

    property p_write_resp;
        (awvalid && awready && wvalid && wready) |=> ##1 bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response late");

endmodule

// ### tb/ppc_pin_model.sv
`timescale 1ns/1ps
module ppc_pin_model (
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] pad_o,
    input wire logic [7:0] pad_oe_n,
    output logic [7:0] pad_i
);
    // Driven pads read back their own level, released pads the outside world
    always_comb pad_i = (pad_o & ~pad_oe_n) | (ext_lvl & pad_oe_n);
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic can_active = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] port_out = 8'h00, port_dir = 8'h00, periph_dig_en = 8'h00, ext_lvl = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] pad_i, pad_o, pad_oe_n;
    ppc_pkg::ppc_pad_t pad_ctrl;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] seed = 8'h1f;
    logic [7:0] cfg [8];

    always #10 aclk = ~aclk;

    ppc_port_cfg dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n(pad_oe_n),
        .pad_ctrl(pad_ctrl), .port_out(port_out), .port_dir(port_dir),
        .periph_dig_en(periph_dig_en), .can_active(can_active), .irq(irq)
    );

    ppc_pin_model pins_u (.ext_lvl(ext_lvl), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pad_i(pad_i));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    function automatic logic [7:0] f_edge(input logic [7:0] p, input logic [7:0] s,
                                          input logic [7:0] n);
        return (p & ~s & n) | (~p & s & ~n);
    endfunction

    // Pull only on inputs or open-drain, open-drain output pullup only, CAN pin pullup only while can_active
    function automatic logic [7:0] f_pull();
        return cfg[1] & (~port_dir | cfg[7]) & ~(port_dir & cfg[7] & cfg[0])
            & ~{7'h00, can_active & cfg[0][0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t bus value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t pin value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        mismatches++;
        $display("ERROR %0t handshake timeout", $time);
        stop_test();
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {seed, seed, seed, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid)
                break;
        end
        bready <= 1'h0;
        if (n == 40)
            timeout();
        chk({30'h0000_0000, bresp}, {30'h0000_0000, er});
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
                break;
        end
        rready <= 1'h0;
        if (n == 40)
            timeout();
        chk(rdata, {24'h00_0000, exp});
        chk({30'h0000_0000, rresp}, {30'h0000_0000, er});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] s, n, m, e;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 8; i++)
            rdchk(ppc_pkg::IDX_POL + 10'(i), 8'h00, i == 6 ? 2'h2 : 2'h0);
        $display("test reset values done");
        for (int k = 0; k < 6; k++)
        begin
            for (int i = 0; i < 8; i++)
                if (i != 3 && i != 6)
                begin
                    cfg[i] = nxt();
                    wr(ppc_pkg::IDX_POL + 10'(i), cfg[i], 2'h0);
                end
            for (int i = 0; i < 8; i++)
                if (i != 3 && i != 6)
                    rdchk(ppc_pkg::IDX_POL + 10'(i), cfg[i], 2'h0);
            wr(10'h2de, nxt(), 2'h2);
            wstrb <= 4'he;
            wr(ppc_pkg::IDX_RDR, ~cfg[5], 2'h0);
            wstrb <= 4'hf;
            rdchk(ppc_pkg::IDX_RDR, cfg[5], 2'h0);
            port_dir <= nxt();
            port_out <= nxt();
            periph_dig_en <= nxt();
            can_active <= seed[2];
            repeat (3) @(posedge aclk);
            chk8(pad_ctrl.pull_en, f_pull());
            chk8(pad_ctrl.pull_dn & f_pull(), cfg[0] & f_pull());
            chk8(pad_ctrl.open_drain, cfg[7]);
            chk8(pad_ctrl.reduced_drv, cfg[5]);
            chk8(pad_ctrl.ibuf_en, cfg[4] | periph_dig_en);
            chk8(pad_oe_n, ~port_dir | (cfg[7] & port_out));
            chk8(pad_o, port_out & ~cfg[7]);
        end
        $display("test register and pad control done");
        wr(ppc_pkg::IDX_OD, 8'h00, 2'h0);
        // Pins treated as analog: buffers off, edges still seen
        periph_dig_en <= 8'h00;
        wr(ppc_pkg::IDX_IBE, 8'h00, 2'h0);
        repeat (2) @(posedge aclk);
        chk8(pad_ctrl.ibuf_en, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            cfg[0] = nxt();
            cfg[2] = nxt();
            wr(ppc_pkg::IDX_POL, cfg[0], 2'h0);
            wr(ppc_pkg::IDX_IE, cfg[2], 2'h0);
            s = nxt();
            port_dir <= k[0] ? 8'hff : 8'h00;
            port_out <= s;
            ext_lvl <= s;
            repeat (6) @(posedge aclk);
            wr(ppc_pkg::IDX_IF, 8'hff, 2'h0);
            n = nxt();
            port_out <= n;
            ext_lvl <= n;
            repeat (6) @(posedge aclk);
            e = f_edge(cfg[0], s, n);
            rdchk(ppc_pkg::IDX_IF, e, 2'h0);
            chk8({7'h00, irq}, {7'h00, |(e & cfg[2])});
            m = nxt();
            wr(ppc_pkg::IDX_IF, m, 2'h0);
            rdchk(ppc_pkg::IDX_IF, e & ~m, 2'h0);
        end
        $display("test pin edges done");
        stop_test();
    end
endmodule
